/* design/ct_core.sv */
// sequencer for traps, returns, wait/stop, tests, transfers and operand forms
`timescale 1ns/1ns
`default_nettype none
`include "ct_map.svh"
// Operation
// RULE1: trap pushes pc, index, acc, flags; masks; vectors
// RULE2: test sets negative and zero, clears overflow
// RULE3: wait clears mask, stops clock until interrupt
// RULE4: extended address fetched high byte then low
// RULE5: long indexed offset high then low, plus index
// RULE6: direct address byte then branch offset byte
// RULE7: short indexed post-increment bumps index after access
// RULE8: stack relative adds unsigned one or two bytes
// RULE9: return pulls flags, acc, index, pc high, low
// RULE10: stop clears mask, halts until wake event
// RULE11: transfers between acc, flags and index low
// RULE12: stack pointer and index move with plus/minus one
module ct_core #(
    parameter logic [15:0] RESET_PC = `CT_RESET_PC
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // program memory, data returns in the same cycle as the read strobe
    output logic [15:0] mem_addr,
    output logic mem_rd,
    output logic mem_wr,
    output logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    // interrupt logic and wake-up pin
    input wire logic irq_req,
    input wire logic wake_pin,
    // core status
    output logic cpu_clk_en,
    output logic stopped,
    output logic [7:0] acc,
    output logic [7:0] flags
);
    ct_pkg::state_t state; // sequencer state
    logic [15:0] pc; // program counter
    logic [15:0] sp; // stack pointer
    logic [15:0] ix; // index pair, high:low
    logic [7:0] opcode; // latched opcode
    logic prefix; // second opcode page
    logic [15:0] opnd; // collected operand bytes
    logic [1:0] nleft; // operand bytes still to fetch
    logic pend; // an operand read is in flight
    logic [3:0] step; // step within an inherent sequence
    logic [7:0] memval; // memory operand kept for compare
    logic wake_meta; // wake synchroniser, first stage
    logic wake_s; // wake synchroniser, second stage

    // operand form of an opcode
    function automatic ct_pkg::mode_t mode_of(input logic pre, input logic [7:0] op);
        if (pre) begin
            case (op)
                `CT_OP_TEST_IX1: mode_of = ct_pkg::stack_short_offset_mode;
                `CT_OP_SUB_IXW: mode_of = ct_pkg::stack_long_offset_mode;
                default: mode_of = ct_pkg::inherent_mode;
            endcase
        end else begin
            case (op)
                `CT_OP_TEST_DIR: mode_of = ct_pkg::direct_mode;
                `CT_OP_TEST_IX1: mode_of = ct_pkg::indexed_short_offset_mode;
                `CT_OP_TEST_IX: mode_of = ct_pkg::indexed_plain_mode;
                `CT_OP_SUB_ABS: mode_of = ct_pkg::extended_mode;
                `CT_OP_SUB_IXW: mode_of = ct_pkg::indexed_long_offset_mode;
                `CT_OP_CBEQ_DIR: mode_of = ct_pkg::direct_plus_branch_offset;
                `CT_OP_CBEQ_IX1P: mode_of = ct_pkg::indexed_short_offset_postinc_mode;
                default: mode_of = ct_pkg::inherent_mode;
            endcase
        end
    endfunction

    // operand address bytes that follow the opcode
    function automatic logic [1:0] bytes_of(input ct_pkg::mode_t m);
        case (m)
            ct_pkg::extended_mode,
            ct_pkg::indexed_long_offset_mode,
            ct_pkg::stack_long_offset_mode: bytes_of = 2'd2;
            ct_pkg::indexed_plain_mode,
            ct_pkg::inherent_mode: bytes_of = 2'd0;
            default: bytes_of = 2'd1;
        endcase
    endfunction

    // test result: n and z from value, v cleared, rest kept
    function automatic logic [7:0] test_flags(input logic [7:0] f, input logic [7:0] v);
        logic [7:0] r;
        r = f;
        r[`CT_FLAG_V] = 1'b0;
        r[`CT_FLAG_N] = v[7];
        r[`CT_FLAG_Z] = (v == 8'h00);
        test_flags = r;
    endfunction

    // decode of incoming and latched opcode
    wire ct_pkg::mode_t dec_mode = mode_of(prefix, mem_rdata);
    wire ct_pkg::mode_t op_mode = mode_of(prefix, opcode);
    wire logic [15:0] ea;

    // subtract acc minus memory, with borrow
    wire logic [8:0] diff = {1'b0, acc} - {1'b0, mem_rdata};
    wire logic sub_v = (acc[7] & ~mem_rdata[7] & ~diff[7]) | (~acc[7] & mem_rdata[7] & diff[7]);

    // byte pushed at each trap step: pc low, pc high, index low, acc, flags
    wire logic [7:0] push_byte = (step == 4'd0) ? pc[7:0] :
                                 (step == 4'd1) ? pc[15:8] :
                                 (step == 4'd2) ? ix[7:0] :
                                 (step == 4'd3) ? acc : flags;
    wire logic [15:0] rel_target = pc + {{8{mem_rdata[7]}}, mem_rdata};
    wire logic is_test = (opcode[3:0] == 4'hd);
    wire logic is_sub = (opcode[3:0] == 4'h0);

    // effective address former
    ct_addr_gen u_addr_gen (
        .mode(op_mode),
        .opnd(opnd),
        .ix(ix),
        .sp(sp),
        .ea(ea)
    );

    // two-flop synchroniser for the wake pin
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wake_meta <= 1'b0;
            wake_s <= 1'b0;
        end else begin
            wake_meta <= wake_pin;
            wake_s <= wake_meta;
        end
    end

    // main sequencer
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            state <= ct_pkg::st_fetch;
            pc <= RESET_PC;
            sp <= `CT_RESET_SP;
            ix <= 16'h0000;
            acc <= 8'h00;
            flags <= `CT_RESET_FLAGS;
            opcode <= 8'h00;
            prefix <= 1'b0;
            opnd <= 16'h0000;
            nleft <= 2'd0;
            pend <= 1'b0;
            step <= 4'd0;
            memval <= 8'h00;
            mem_addr <= 16'h0000;
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_wdata <= 8'h00;
            cpu_clk_en <= 1'b1;
            stopped <= 1'b0;
        end else begin
            // strobes last one cycle
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            case (state)
                ct_pkg::st_fetch: begin
                    prefix <= 1'b0;
                    step <= 4'd0;
                    // pending unmasked interrupt enters the stacking sequence
                    if (irq_req && !flags[`CT_FLAG_I]) begin
                        opcode <= `CT_OP_TRAP;
                        state <= ct_pkg::st_exec;
                    end else begin
                        mem_addr <= pc;
                        mem_rd <= 1'b1;
                        pc <= pc + 16'h0001;
                        state <= ct_pkg::st_op;
                    end
                end
                ct_pkg::st_op: begin
                    opnd <= 16'h0000;
                    pend <= 1'b0;
                    if (!prefix && mem_rdata == `CT_OP_PREFIX) begin
                        // second page, fetch the real opcode
                        prefix <= 1'b1;
                        mem_addr <= pc;
                        mem_rd <= 1'b1;
                        pc <= pc + 16'h0001;
                    end else begin
                        opcode <= mem_rdata;
                        nleft <= bytes_of(dec_mode);
                        if (dec_mode == ct_pkg::inherent_mode) begin
                            state <= ct_pkg::st_exec;
                        end else begin
                            state <= ct_pkg::st_opnd;
                        end
                    end
                end
                ct_pkg::st_opnd: begin
                    // bytes shift in, first fetched ends up high
                    if (pend) begin
                        opnd <= {opnd[7:0], mem_rdata}; // see RULE4 RULE5 RULE8
                    end
                    if (nleft != 2'd0) begin
                        mem_addr <= pc;
                        mem_rd <= 1'b1;
                        pc <= pc + 16'h0001;
                        nleft <= nleft - 2'd1;
                        pend <= 1'b1;
                    end else begin
                        pend <= 1'b0;
                        state <= ct_pkg::st_addr;
                    end
                end
                ct_pkg::st_addr: begin
                    mem_addr <= ea;
                    mem_rd <= 1'b1;
                    state <= ct_pkg::st_mem;
                end
                ct_pkg::st_mem: begin
                    if (is_test) begin
                        flags <= test_flags(flags, mem_rdata); // see RULE2
                        state <= ct_pkg::st_fetch;
                    end else if (is_sub) begin
                        acc <= diff[7:0];
                        flags[`CT_FLAG_V] <= sub_v;
                        flags[`CT_FLAG_N] <= diff[7];
                        flags[`CT_FLAG_Z] <= (diff[7:0] == 8'h00);
                        flags[`CT_FLAG_C] <= diff[8];
                        state <= ct_pkg::st_fetch;
                    end else begin
                        // compare-and-branch: offset byte follows the address
                        memval <= mem_rdata;
                        if (op_mode == ct_pkg::indexed_short_offset_postinc_mode) begin
                            ix <= ix + 16'h0001; // see RULE7
                        end
                        mem_addr <= pc;
                        mem_rd <= 1'b1;
                        pc <= pc + 16'h0001; // see RULE6
                        state <= ct_pkg::st_rel;
                    end
                end
                ct_pkg::st_rel: begin
                    if (acc == memval) begin
                        pc <= rel_target; // see RULE6
                    end
                    state <= ct_pkg::st_fetch;
                end
                ct_pkg::st_exec: begin
                    state <= ct_pkg::st_fetch;
                    if (!prefix) begin
                        case (opcode)
                            `CT_OP_TRAP: begin
                                state <= ct_pkg::st_exec;
                                step <= step + 4'd1;
                                if (step <= 4'd4) begin
                                    mem_addr <= sp;
                                    mem_wdata <= push_byte;
                                    mem_wr <= 1'b1;
                                    sp <= sp - 16'h0001; // see RULE1
                                end else if (step == 4'd5) begin
                                    flags[`CT_FLAG_I] <= 1'b1; // see RULE1
                                    mem_addr <= `CT_TRAP_VEC;
                                    mem_rd <= 1'b1;
                                end else if (step == 4'd6) begin
                                    mem_addr <= `CT_TRAP_VEC + 16'h0001;
                                    mem_rd <= 1'b1;
                                    pc[15:8] <= mem_rdata;
                                end else begin
                                    pc[7:0] <= mem_rdata; // see RULE1
                                    state <= ct_pkg::st_fetch;
                                end
                            end
                            `CT_OP_RETURN: begin
                                state <= ct_pkg::st_exec;
                                step <= step + 4'd1;
                                if (step <= 4'd4) begin
                                    mem_addr <= sp + 16'h0001;
                                    mem_rd <= 1'b1;
                                    sp <= sp + 16'h0001; // see RULE9
                                end
                                case (step)
                                    4'd1: flags <= mem_rdata | `CT_FLAG_ONES;
                                    4'd2: acc <= mem_rdata;
                                    4'd3: ix[7:0] <= mem_rdata;
                                    4'd4: pc[15:8] <= mem_rdata;
                                    4'd5: begin
                                        pc[7:0] <= mem_rdata; // see RULE9
                                        state <= ct_pkg::st_fetch;
                                    end
                                    default: ;
                                endcase
                            end
                            `CT_OP_WAIT: begin
                                flags[`CT_FLAG_I] <= 1'b0;
                                cpu_clk_en <= 1'b0; // see RULE3
                                state <= ct_pkg::st_wait;
                            end
                            `CT_OP_STOP: begin
                                flags[`CT_FLAG_I] <= 1'b0;
                                stopped <= 1'b1; // see RULE10
                                state <= ct_pkg::st_stop;
                            end
                            `CT_OP_TAP: flags <= acc | `CT_FLAG_ONES; // see RULE11
                            `CT_OP_FLAGS_TO_ACC: acc <= flags; // see RULE11
                            `CT_OP_TAX: ix[7:0] <= acc; // see RULE11
                            `CT_OP_TXA: acc <= ix[7:0]; // see RULE11
                            `CT_OP_TEST_A: flags <= test_flags(flags, acc); // see RULE2
                            `CT_OP_TEST_X: flags <= test_flags(flags, ix[7:0]); // see RULE2
                            `CT_OP_SP_TO_INDEX: begin
                                // second cycle of the two-cycle move
                                if (step == 4'd0) begin
                                    step <= 4'd1;
                                    state <= ct_pkg::st_exec;
                                end else begin
                                    ix <= sp + 16'h0001; // see RULE12
                                end
                            end
                            `CT_OP_INDEX_TO_SP: begin
                                if (step == 4'd0) begin
                                    step <= 4'd1;
                                    state <= ct_pkg::st_exec;
                                end else begin
                                    sp <= ix - 16'h0001; // see RULE12
                                end
                            end
                            default: ;
                        endcase
                    end
                end
                ct_pkg::st_wait: begin
                    // clock gated until an interrupt request
                    if (irq_req) begin
                        cpu_clk_en <= 1'b1; // see RULE3
                        state <= ct_pkg::st_fetch;
                    end
                end
                ct_pkg::st_stop: begin
                    if (wake_s) begin
                        stopped <= 1'b0; // see RULE10
                        state <= ct_pkg::st_fetch;
                    end
                end
                default: state <= ct_pkg::st_fetch;
            endcase
        end
    end
endmodule
`default_nettype wire

/* design/ct_map.svh */
// constants for the instruction tail decoder: opcodes, flag bits, vectors, resets
`ifndef CT_MAP_SVH
`define CT_MAP_SVH

// opcodes handled by the core
`define CT_OP_PREFIX 8'h9e
`define CT_OP_TRAP 8'h83
`define CT_OP_RETURN 8'h80
`define CT_OP_WAIT 8'h8f
`define CT_OP_STOP 8'h8e
`define CT_OP_TAP 8'h84
`define CT_OP_FLAGS_TO_ACC 8'h85
`define CT_OP_TAX 8'h97
`define CT_OP_TXA 8'h9f
`define CT_OP_SP_TO_INDEX 8'h95
`define CT_OP_INDEX_TO_SP 8'h94
`define CT_OP_TEST_A 8'h4d
`define CT_OP_TEST_X 8'h5d
`define CT_OP_TEST_DIR 8'h3d
`define CT_OP_TEST_IX1 8'h6d
`define CT_OP_TEST_IX 8'h7d
`define CT_OP_SUB_ABS 8'hc0
`define CT_OP_SUB_IXW 8'hd0
`define CT_OP_CBEQ_DIR 8'h31
`define CT_OP_CBEQ_IX1P 8'h61

// flag bit positions
`define CT_FLAG_V 7
`define CT_FLAG_H 4
`define CT_FLAG_I 3
`define CT_FLAG_N 2
`define CT_FLAG_Z 1
`define CT_FLAG_C 0
`define CT_FLAG_ONES 8'h60

// vectors and reset values
`define CT_TRAP_VEC 16'hfffc
`define CT_RESET_PC 16'h8000
`define CT_RESET_SP 16'h00ff
`define CT_RESET_FLAGS 8'h68

`endif

/* design/ct_pkg.sv */
// types shared by the instruction tail decoder files
package ct_pkg;
    // sequencer states, one-hot
    typedef enum logic [8:0] {
        st_fetch = 9'h001,
        st_op = 9'h002,
        st_opnd = 9'h004,
        st_addr = 9'h008,
        st_mem = 9'h010,
        st_rel = 9'h020,
        st_exec = 9'h040,
        st_wait = 9'h080,
        st_stop = 9'h100
    } state_t;

    // addressing forms of the operand
    typedef enum logic [3:0] {
        inherent_mode,
        direct_mode,
        extended_mode,
        indexed_long_offset_mode,
        indexed_short_offset_mode,
        indexed_plain_mode,
        stack_short_offset_mode,
        stack_long_offset_mode,
        indexed_short_offset_postinc_mode,
        direct_plus_branch_offset
    } mode_t;
endpackage

/* design/ct_addr_gen.sv */
// effective address former for the memory addressing forms
`timescale 1ns/1ns
`default_nettype none
module ct_addr_gen (
    // addressing form and operand bytes
    input wire ct_pkg::mode_t mode,
    input wire logic [15:0] opnd,
    // base registers
    input wire logic [15:0] ix,
    input wire logic [15:0] sp,
    // resulting address
    output logic [15:0] ea
);
    // short offset zero-extended, long offset taken whole
    wire logic [15:0] short_off = {8'h00, opnd[7:0]};

    // address selection per form
    always_comb begin
        case (mode)
            ct_pkg::direct_mode: ea = short_off;
            ct_pkg::direct_plus_branch_offset: ea = short_off; // see RULE6
            ct_pkg::extended_mode: ea = opnd; // see RULE4
            ct_pkg::indexed_long_offset_mode: ea = ix + opnd; // see RULE5
            ct_pkg::indexed_short_offset_mode: ea = ix + short_off;
            ct_pkg::indexed_short_offset_postinc_mode: ea = ix + short_off; // see RULE7
            ct_pkg::indexed_plain_mode: ea = ix;
            ct_pkg::stack_short_offset_mode: ea = sp + short_off; // see RULE8
            ct_pkg::stack_long_offset_mode: ea = sp + opnd; // see RULE8
            default: ea = 16'h0000;
        endcase
    end
endmodule
`default_nettype wire

/* testbench/ct_mem_model.sv */
// synchronous memory model standing on the far side of the core's bus
`timescale 1ns/1ns
`default_nettype none
module ct_mem_model (
    // clock
    input wire logic clk_sys,
    // bus from the core
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    // read data back to the core
    output logic [7:0] mem_rdata
);
    // whole byte space, preloaded by the bench
    logic [7:0] mem [0:65535];
    // filler driven while no read is pending
    logic [7:0] junk = 8'h3c;

    // writes land at the strobe; filler moves every cycle
    always @(posedge clk_sys) begin
        if (mem_wr) begin
            mem[mem_addr] <= mem_wdata;
        end
        junk <= junk + 8'h35;
    end

    // data valid in the same cycle as the read strobe, junk otherwise
    assign mem_rdata = mem_rd ? mem[mem_addr] : junk;
endmodule
`default_nettype wire

/* testbench/ct_tail_monitor.sv */
// concurrent checks on the instruction tail decoder ports
`timescale 1ns/1ns
`default_nettype none
module ct_tail_monitor (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // memory bus
    input wire logic [15:0] mem_addr,
    input wire logic mem_rd,
    input wire logic mem_wr,
    input wire logic [7:0] mem_wdata,
    input wire logic [7:0] mem_rdata,
    // interrupt and wake inputs
    input wire logic irq_req,
    input wire logic wake_pin,
    // core status
    input wire logic cpu_clk_en,
    input wire logic stopped,
    input wire logic [7:0] acc,
    input wire logic [7:0] flags
);
    default clocking mon_cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // five back-to-back pushes of a trap frame
    sequence push_five;
        mem_wr [*5];
    endsequence

    // vector high byte then low byte read
    sequence vector_fetch;
        (mem_rd && mem_addr == 16'hfffc) ##1 (mem_rd && mem_addr == 16'hfffd);
    endsequence

    chk_push_descend: assert property (mem_wr ##1 mem_wr |-> mem_addr == $past(mem_addr) - 16'h0001)
        else $error("push address did not step down");
    chk_trap_vector: assert property (push_five |-> ##[1:3] vector_fetch)
        else $error("vector not fetched after trap frame");
    chk_trap_mask: assert property (push_five |-> ##[1:4] flags[3])
        else $error("mask not set after trap frame");
    chk_wait_mask: assert property (!cpu_clk_en |-> !flags[3])
        else $error("mask set while clock gated");
    chk_wait_quiet: assert property (!cpu_clk_en |-> !mem_rd && !mem_wr)
        else $error("bus active while clock gated");
    chk_wait_wake: assert property (!cpu_clk_en && irq_req |-> ##[1:2] cpu_clk_en)
        else $error("clock not resumed on interrupt");
    chk_stop_mask: assert property (stopped |-> !flags[3] && !mem_rd && !mem_wr)
        else $error("stop state not quiet or mask set");
    chk_stop_wake: assert property (stopped && wake_pin |-> ##[1:4] !stopped)
        else $error("stop not left on wake");
    chk_stop_hold: assert property (stopped && !wake_pin && !$past(wake_pin)
        && !$past(wake_pin, 2) && !$past(wake_pin, 3) |=> stopped)
        else $error("stop left without wake");
    chk_flag_ones: assert property (flags[6:5] == 2'b11)
        else $error("fixed flag bits not one");
endmodule

bind ct_core ct_tail_monitor i_mon (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .mem_addr(mem_addr),
    .mem_rd(mem_rd),
    .mem_wr(mem_wr),
    .mem_wdata(mem_wdata),
    .mem_rdata(mem_rdata),
    .irq_req(irq_req),
    .wake_pin(wake_pin),
    .cpu_clk_en(cpu_clk_en),
    .stopped(stopped),
    .acc(acc),
    .flags(flags)
);
`default_nettype wire

/* testbench/tb_top.sv */
// self-checking bench running a small program through the core
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    // design ports
    logic clk_sys;
    logic rst_n;
    logic irq_req;
    logic wake_pin;
    logic [15:0] mem_addr;
    logic mem_rd;
    logic mem_wr;
    logic [7:0] mem_wdata;
    logic [7:0] mem_rdata;
    logic cpu_clk_en;
    logic stopped;
    logic [7:0] acc;
    logic [7:0] flags;
    // bookkeeping and random operands
    int mismatches;
    int checked;
    int seed;
    logic [7:0] v, a, f1, s2, f2, a2, x2, m5, m8, e;
    // program image from 8000
    logic [7:0] prog [0:36];

    ct_core i_dut (.clk_sys(clk_sys), .rst_n(rst_n), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .irq_req(irq_req),
        .wake_pin(wake_pin), .cpu_clk_en(cpu_clk_en), .stopped(stopped), .acc(acc),
        .flags(flags));
    ct_mem_model i_mem (.clk_sys(clk_sys), .mem_addr(mem_addr), .mem_rd(mem_rd),
        .mem_wr(mem_wr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata));

    // 25 MHz clock
    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // flags expected after a subtract
    function automatic logic [7:0] sub_f(input logic [7:0] x, input logic [7:0] m,
        input logic [7:0] old);
        logic [7:0] r;
        r = x - m;
        sub_f = {(x[7] ^ m[7]) & (x[7] ^ r[7]), 2'b11, old[4:3], r[7], r == 8'h00, m > x};
    endfunction

    // compare and count
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            mismatches++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // verdict and end of run
    task automatic finish_test;
        if (mismatches == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask

    // bounded wait: 0 fetch at address, 1 clock gated, 2 stopped
    task automatic wait_for(input int kind, input logic [15:0] ad);
        int n;
        for (n = 0; n < 300; n++) begin
            @(posedge clk_sys);
            if (kind == 0 && mem_rd === 1'b1 && mem_addr === ad) break;
            if (kind == 1 && cpu_clk_en === 1'b0) break;
            if (kind == 2 && stopped === 1'b1) break;
        end
        if (n == 300) begin
            mismatches++;
            finish_test();
        end
    endtask

    // main sequence: corner subtrahends then a random one
    initial begin
        seed = 32'ha2dbf30b;
        rst_n = 1'b0;
        irq_req = 1'b0;
        wake_pin = 1'b0;
        mismatches = 0;
        checked = 0;
        prog = '{8'hc0, 8'h12, 8'h34, 8'h4d, 8'h97, 8'h85, 8'h83, 8'h9f, 8'h95, 8'h9f,
            8'h61, 8'hf0, 8'h03, 8'h8e, 8'h8e, 8'h8e, 8'h9f, 8'h31, 8'h40, 8'h02, 8'h8e,
            8'h8e, 8'hd0, 8'h00, 8'h20, 8'h9e, 8'hd0, 8'h00, 8'h10, 8'h9e, 8'h6d, 8'h81,
            8'h8f, 8'h8e, 8'h84, 8'h5d, 8'h8e};
        for (int it = 0; it < 3; it++) begin
            v = (it == 0) ? 8'h80 : (it == 1) ? 8'h00 : 8'($random(seed));
            f2 = 8'($random(seed)) | 8'h08;
            a2 = 8'($random(seed));
            x2 = 8'($random(seed));
            m5 = 8'($random(seed));
            m8 = 8'($random(seed));
            for (int i = 0; i < 37; i++) i_mem.mem[16'h8000 + i] = prog[i];
            // operands, with byte-swapped or signed decoys holding other values
            i_mem.mem[16'h1234] = v;
            i_mem.mem[16'h3412] = ~v;
            i_mem.mem[16'hfffc] = 8'h90;
            i_mem.mem[16'hfffd] = 8'h00;
            i_mem.mem[16'h9000] = 8'h80;
            i_mem.mem[16'h01f0] = 8'h00;
            i_mem.mem[16'h0040] = 8'h01;
            i_mem.mem[16'h0121] = m5;
            i_mem.mem[16'h2101] = ~m5;
            i_mem.mem[16'h010f] = m8;
            i_mem.mem[16'h10ff] = ~m8;
            i_mem.mem[16'h0180] = 8'h00;
            i_mem.mem[16'h0080] = 8'h80;
            @(posedge clk_sys) rst_n <= 1'b0;
            repeat (5) @(posedge clk_sys);
            rst_n <= 1'b1;
            wait_for(0, 16'h8000);
            chk({acc, flags}, 16'h0068);
            wait_for(0, 16'h8003);
            a = 8'h00 - v;
            f1 = sub_f(8'h00, v, 8'h68);
            chk({acc, flags}, {a, f1});
            wait_for(0, 16'h8004);
            s2 = {1'b0, f1[6:3], a[7], a == 8'h00, f1[0]};
            chk({acc, flags}, {a, s2});
            wait_for(0, 16'h8006);
            chk({8'h00, acc}, {8'h00, s2});
            wait_for(0, 16'h9000);
            chk({i_mem.mem[16'h00ff], i_mem.mem[16'h00fe]}, 16'h0780);
            chk({i_mem.mem[16'h00fd], i_mem.mem[16'h00fc]}, {a, s2});
            chk({i_mem.mem[16'h00fb], flags}, {s2, s2 | 8'h08});
            // new frame for the return to pull
            i_mem.mem[16'h00fb] = f2;
            i_mem.mem[16'h00fc] = a2;
            i_mem.mem[16'h00fd] = x2;
            wait_for(0, 16'h8007);
            chk({acc, flags}, {a2, f2 | 8'h60});
            wait_for(0, 16'h8008);
            chk({8'h00, acc}, {8'h00, x2});
            wait_for(0, 16'h800a);
            chk({8'h00, acc}, 16'h0000);
            wait_for(0, 16'h8011);
            chk({8'h00, acc}, 16'h0001);
            wait_for(0, 16'h8019);
            e = 8'h01 - m5;
            chk({8'h00, acc}, {8'h00, e});
            wait_for(0, 16'h801d);
            e = e - m8;
            chk({8'h00, acc}, {8'h00, e});
            wait_for(0, 16'h8020);
            chk({13'h0000, flags[7], flags[2:1]}, 16'h0001);
            wait_for(1, 16'h0000);
            chk({15'h0000, flags[3]}, 16'h0000);
            irq_req <= 1'b1;
            wait_for(0, 16'h9000);
            irq_req <= 1'b0;
            wait_for(0, 16'h8021);
            chk({15'h0000, cpu_clk_en}, 16'h0001);
            wait_for(2, 16'h0000);
            chk({15'h0000, flags[3]}, 16'h0000);
            wake_pin <= 1'b1;
            wait_for(0, 16'h8022);
            chk({15'h0000, stopped}, 16'h0000);
            wake_pin <= 1'b0;
            wait_for(0, 16'h8023);
            chk({8'h00, flags}, {8'h00, e | 8'h60});
            wait_for(0, 16'h8024);
            chk({8'h00, flags}, {8'h00, (e | 8'h60) & 8'h79});
        end
        finish_test();
    end
endmodule
`default_nettype wire
